// file: common/cdhls_pkg.sv
/*
 * Constants, types and cycle counts for the four-lane D-PHY transmit lane sequencer.
 * Assumes a 100 MHz system clock and a separate link clock of one UI per rising edge.
 */
package cdhls_pkg;
	localparam int LANES = 4;
	localparam int CLK_PS = 10000;
	// Link rate and UI bounds, in Mbps, MHz and ps
	localparam int DBR_MIN_MBPS = 150;
	localparam int DBR_MAX_MBPS = 600;
	localparam int FCLK_MAX_MHZ = 300;
	localparam int UI_MIN_PS = 1670;
	localparam int UI_MAX_PS = 13330;
	localparam int UI_INST_PS = 1131;
	// Timings in ns
	localparam int T_LPX_NS = 50;
	localparam int T_CLK_PRE_NS = 8;
	localparam int T_CLK_PREP_MIN_NS = 38;
	localparam int T_CLK_PREP_MAX_NS = 95;
	localparam int T_CLK_PZ_NS = 300;
	localparam int T_HS_PREP_MAX_NS = 85;
	localparam int T_HS_PZ_NS = 145;
	localparam int T_TRAIL_NS = 60;
	localparam int T_EOT_NS = 105;
	localparam int T_EXIT_NS = 100;
	localparam int T_LINK_LAT_NS = 150;
	localparam logic [7:0] SYNC_BYTE = 8'hB8;
	function automatic int cdiv(input int a, input int b);
		return (a + b - 1) / b;
	endfunction : cdiv
	function automatic int imax(input int a, input int b);
		return (a > b) ? a : b;
	endfunction : imax
	// Cycle counts, least times rounded up, longest times down
	localparam logic [7:0] C_LPX = 8'(cdiv(T_LPX_NS * 1000, CLK_PS));
	localparam logic [7:0] C_CLK_PREP = 8'(cdiv(T_CLK_PREP_MIN_NS * 1000, CLK_PS));
	localparam logic [7:0] C_CLK_PREP_MAX = 8'((T_CLK_PREP_MAX_NS * 1000) / CLK_PS);
	localparam logic [7:0] C_CLK_PZ = 8'(cdiv(T_CLK_PZ_NS * 1000, CLK_PS));
	localparam logic [7:0] C_CLK_ZERO = C_CLK_PZ - C_CLK_PREP;
	localparam logic [7:0] C_PRE_WAIT = 8'(cdiv((T_CLK_PRE_NS + T_LINK_LAT_NS) * 1000, CLK_PS));
	localparam logic [7:0] C_HS_PREP = C_LPX;
	localparam logic [7:0] C_HS_PREP_MAX = 8'((T_HS_PREP_MAX_NS * 1000 + 6 * UI_MIN_PS) / CLK_PS);
	localparam logic [7:0] C_HS_PZ = 8'(cdiv(T_HS_PZ_NS * 1000 + 10 * UI_MAX_PS, CLK_PS));
	localparam logic [7:0] C_HS_ZERO = C_HS_PZ - C_HS_PREP;
	localparam logic [7:0] C_TRAIL = 8'(cdiv(imax(8 * UI_MAX_PS, T_TRAIL_NS * 1000 + 4 * UI_MAX_PS), CLK_PS));
	localparam logic [7:0] C_EOT_MAX = 8'((T_EOT_NS * 1000 + 12 * UI_MIN_PS) / CLK_PS);
	localparam logic [7:0] C_EXIT = 8'(cdiv(T_EXIT_NS * 1000, CLK_PS));
	localparam logic [3:0] C_BITS = 4'h8;
	typedef enum logic [2:0] {CK_OFF, CK_REQ, CK_PREP, CK_ZERO, CK_RUN} cdhls_ck_st_t;
	typedef enum logic [2:0] {D_STOP, D_REQ, D_PREP, D_ZERO, D_SYNC, D_PAY, D_TRAIL} cdhls_d_st_t;
	typedef struct packed {logic lp_p; logic lp_n; logic hs_en;} cdhls_lp_t;
	localparam cdhls_lp_t LP_STOP = 3'b110;
	localparam cdhls_lp_t LP_REQ = 3'b010;
	localparam cdhls_lp_t LP_PREP = 3'b000;
	localparam cdhls_lp_t LP_HS = 3'b001;
	typedef struct packed {logic valid; logic last; logic [LANES-1:0][7:0] data;} cdhls_pay_t;
	typedef struct packed {
		cdhls_ck_st_t cst;
		cdhls_d_st_t dst;
		logic [7:0] ccnt;
		logic [7:0] dcnt;
		logic pre_ok;
		logic run;
		logic req;
		logic fin;
		logic trail;
		logic ack_s1;
		logic ack_s2;
		cdhls_lp_t ck_o;
		cdhls_lp_t d_o;
		logic [LANES-1:0][7:0] txb;
		logic [LANES-1:0] lastb;
	} cdhls_sys_t;
	localparam cdhls_sys_t SYS_RST = '{cst: CK_OFF, dst: D_STOP, ck_o: LP_STOP, d_o: LP_STOP, default: '0};
	typedef struct packed {
		logic ce_s1;
		logic ce_s2;
		logic run_s1;
		logic run_s2;
		logic rq_s1;
		logic rq_s2;
		logic rq_seen;
		logic ack;
		logic ck;
		logic [3:0] cnt;
		logic [LANES-1:0][7:0] sh;
		logic [LANES-1:0] bitv;
	} cdhls_lnk_t;
endpackage : cdhls_pkg

// file: logic/cdhls_lane_seq.sv
/*
 * Lane sequencer: clock-lane bring-up, data-lane burst sequencing and the
 * link-clock serializer for four configurable differential lanes.
 * Assumes configuration and payload come from logic on clk; link_clk is the
 * bit clock (one UI per rising edge) and is free running while the block is enabled.
 */
module cdhls_lane_seq (
	// System clock domain
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Link clock domain
	input wire logic link_clk,
	// Configuration
	input wire logic cfg_enable,
	input wire logic [cdhls_pkg::LANES-1:0] cfg_lane_is_clk,
	input wire logic [cdhls_pkg::LANES-1:0] cfg_inv_p,
	input wire logic [cdhls_pkg::LANES-1:0] cfg_inv_n,
	// Payload stream
	input wire cdhls_pkg::cdhls_pay_t pay,
	output logic pay_ready,
	// Lane wires
	output logic [cdhls_pkg::LANES-1:0] wire_p,
	output logic [cdhls_pkg::LANES-1:0] wire_n,
	output logic [cdhls_pkg::LANES-1:0] lane_hs,
	// Status
	output logic clk_running
);
	cdhls_pkg::cdhls_sys_t r;
	cdhls_pkg::cdhls_sys_t n;
	cdhls_pkg::cdhls_lnk_t q;
	cdhls_pkg::cdhls_lnk_t m;
	logic busy;

	// Line levels of the clock lane per state
	function automatic cdhls_pkg::cdhls_lp_t ck_pins(input cdhls_pkg::cdhls_ck_st_t s);
		unique case (s)
			cdhls_pkg::CK_OFF: ck_pins = cdhls_pkg::LP_STOP;
			cdhls_pkg::CK_REQ: ck_pins = cdhls_pkg::LP_REQ;
			cdhls_pkg::CK_PREP: ck_pins = cdhls_pkg::LP_PREP;
			cdhls_pkg::CK_ZERO: ck_pins = cdhls_pkg::LP_HS;
			cdhls_pkg::CK_RUN: ck_pins = cdhls_pkg::LP_HS;
		endcase
	endfunction : ck_pins

	// Line levels of a data lane per state
	function automatic cdhls_pkg::cdhls_lp_t d_pins(input cdhls_pkg::cdhls_d_st_t s);
		unique case (s)
			cdhls_pkg::D_STOP: d_pins = cdhls_pkg::LP_STOP;
			cdhls_pkg::D_REQ: d_pins = cdhls_pkg::LP_REQ;
			cdhls_pkg::D_PREP: d_pins = cdhls_pkg::LP_PREP;
			default: d_pins = cdhls_pkg::LP_HS;
		endcase
	endfunction : d_pins

	// Legal successor of each burst state
	function automatic cdhls_pkg::cdhls_d_st_t d_succ(input cdhls_pkg::cdhls_d_st_t s);
		unique case (s)
			cdhls_pkg::D_STOP: d_succ = cdhls_pkg::D_REQ;
			cdhls_pkg::D_REQ: d_succ = cdhls_pkg::D_PREP;
			cdhls_pkg::D_PREP: d_succ = cdhls_pkg::D_ZERO;
			cdhls_pkg::D_ZERO: d_succ = cdhls_pkg::D_SYNC;
			cdhls_pkg::D_SYNC: d_succ = cdhls_pkg::D_PAY;
			cdhls_pkg::D_PAY: d_succ = cdhls_pkg::D_TRAIL;
			default: d_succ = cdhls_pkg::D_STOP;
		endcase
	endfunction : d_succ

	// A byte is in flight until the link returns the handshake
	assign busy = (r.req != r.ack_s2);
	assign clk_running = r.pre_ok;

	// System-domain next state
	always_comb begin
		n = r;
		pay_ready = 1'b0;
		if (ce) begin
			n.ack_s1 = q.ack;
			n.ack_s2 = r.ack_s1;
			n.ccnt = r.ccnt + 8'h01;
			n.dcnt = r.dcnt + 8'h01;
			// Clock lane bring-up, then free running
			unique case (r.cst)
				cdhls_pkg::CK_OFF: begin
					if (r.ccnt >= cdhls_pkg::C_LPX - 8'h01) begin
						n.ccnt = r.ccnt;
						if (cfg_enable) begin
							n.cst = cdhls_pkg::CK_REQ;
							n.ccnt = '0;
						end
					end
				end
				cdhls_pkg::CK_REQ: begin
					if (r.ccnt == cdhls_pkg::C_LPX - 8'h01) begin
						n.cst = cdhls_pkg::CK_PREP;
						n.ccnt = '0;
					end
				end
				cdhls_pkg::CK_PREP: begin
					if (r.ccnt == cdhls_pkg::C_CLK_PREP - 8'h01) begin
						n.cst = cdhls_pkg::CK_ZERO;
						n.ccnt = '0;
					end
				end
				cdhls_pkg::CK_ZERO: begin
					if (r.ccnt == cdhls_pkg::C_CLK_ZERO - 8'h01) begin
						n.cst = cdhls_pkg::CK_RUN;
						n.run = 1'b1;
						n.ccnt = '0;
					end
				end
				cdhls_pkg::CK_RUN: begin
					// Hold off data until the toggling clock has reached the pins
					if (r.ccnt == cdhls_pkg::C_PRE_WAIT) begin
						n.ccnt = r.ccnt;
						n.pre_ok = 1'b1;
					end
				end
			endcase
			// Clock leaves high speed only on disable, never mid burst
			if (!cfg_enable && r.dst == cdhls_pkg::D_STOP && r.cst != cdhls_pkg::CK_OFF) begin
				n.cst = cdhls_pkg::CK_OFF;
				n.run = 1'b0;
				n.pre_ok = 1'b0;
				n.ccnt = '0;
			end
			// Data burst sequence
			unique case (r.dst)
				cdhls_pkg::D_STOP: begin
					if (r.dcnt >= cdhls_pkg::C_EXIT) begin
						n.dcnt = r.dcnt;
						if (r.pre_ok && cfg_enable && pay.valid) begin
							n.dst = cdhls_pkg::D_REQ;
							n.dcnt = '0;
						end
					end
				end
				cdhls_pkg::D_REQ: begin
					if (r.dcnt == cdhls_pkg::C_LPX - 8'h01) begin
						n.dst = cdhls_pkg::D_PREP;
						n.dcnt = '0;
					end
				end
				cdhls_pkg::D_PREP: begin
					if (r.dcnt == cdhls_pkg::C_HS_PREP - 8'h01) begin
						n.dst = cdhls_pkg::D_ZERO;
						n.dcnt = '0;
					end
				end
				cdhls_pkg::D_ZERO: begin
					if (r.dcnt == cdhls_pkg::C_HS_ZERO - 8'h01) begin
						n.dst = cdhls_pkg::D_SYNC;
						n.txb = {cdhls_pkg::LANES{cdhls_pkg::SYNC_BYTE}};
						n.req = ~r.req;
						n.fin = 1'b0;
					end
				end
				cdhls_pkg::D_SYNC: begin
					if (!busy) begin
						n.dst = cdhls_pkg::D_PAY;
					end
				end
				cdhls_pkg::D_PAY: begin
					if (!busy) begin
						if (r.fin) begin
							n.dst = cdhls_pkg::D_TRAIL;
							n.dcnt = '0;
						end else if (pay.valid) begin
							n.txb = pay.data;
							n.req = ~r.req;
							n.fin = pay.last;
							pay_ready = 1'b1;
							for (int j = 0; j < cdhls_pkg::LANES; j++) begin
								n.lastb[j] = pay.data[j][7];
							end
						end
					end
				end
				cdhls_pkg::D_TRAIL: begin
					if (r.dcnt == cdhls_pkg::C_TRAIL - 8'h01) begin
						n.dst = cdhls_pkg::D_STOP;
						n.dcnt = '0;
					end
				end
				default: begin
					n.dst = cdhls_pkg::D_STOP;
					n.dcnt = '0;
				end
			endcase
			n.ck_o = ck_pins(n.cst);
			n.d_o = d_pins(n.dst);
			n.trail = (n.dst == cdhls_pkg::D_TRAIL);
		end
	end

	// System-domain state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= cdhls_pkg::SYS_RST;
		end else begin
			r <= n;
		end
	end

	// Link-domain next state: clock toggler and per-lane serializer
	always_comb begin
		m = q;
		m.ce_s1 = ce;
		m.ce_s2 = q.ce_s1;
		if (q.ce_s2) begin
			m.run_s1 = r.run;
			m.run_s2 = q.run_s1;
			m.rq_s1 = r.req;
			m.rq_s2 = q.rq_s1;
			m.ck = q.run_s2 ? ~q.ck : 1'b0;
			if (q.cnt != 4'h0) begin
				// One bit per rising link_clk edge, least significant first
				for (int j = 0; j < cdhls_pkg::LANES; j++) begin
					m.bitv[j] = q.sh[j][0];
					m.sh[j] = {1'b0, q.sh[j][7:1]};
				end
				m.cnt = q.cnt - 4'h1;
				if (q.cnt == 4'h1) begin
					m.ack = q.rq_seen;
				end
			end else begin
				m.bitv = '0;
				if (q.rq_s2 != q.rq_seen) begin
					m.sh = r.txb;
					m.cnt = cdhls_pkg::C_BITS;
					m.rq_seen = q.rq_s2;
				end
			end
		end
	end

	// Link-domain state register
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= m;
		end
	end

	// Lane role select and per-wire polarity
	for (genvar i = 0; i < cdhls_pkg::LANES; i++) begin : g_lane
		cdhls_pkg::cdhls_lp_t sel;
		logic hs_bit;
		assign sel = cfg_lane_is_clk[i] ? r.ck_o : r.d_o;
		assign hs_bit = cfg_lane_is_clk[i] ? q.ck : (r.trail ? ~r.lastb[i] : q.bitv[i]);
		assign wire_p[i] = (sel.hs_en ? hs_bit : sel.lp_p) ^ cfg_inv_p[i];
		assign wire_n[i] = (sel.hs_en ? ~hs_bit : sel.lp_n) ^ cfg_inv_n[i];
		assign lane_hs[i] = sel.hs_en;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	chk_clk_stays_hs: assert property ((r.cst == cdhls_pkg::CK_RUN && cfg_enable) |=> r.cst == cdhls_pkg::CK_RUN)
		else $error("clock lane left high speed while enabled");
	chk_clk_pre_time: assert property ((r.dst == cdhls_pkg::D_STOP && n.dst == cdhls_pkg::D_REQ)
		|-> (r.cst == cdhls_pkg::CK_RUN && r.ccnt == cdhls_pkg::C_PRE_WAIT))
		else $error("data lane left low power before clock ran");
	chk_clk_prep_len: assert property ((r.cst == cdhls_pkg::CK_PREP && n.cst == cdhls_pkg::CK_ZERO)
		|-> (r.ccnt + 8'h01 >= cdhls_pkg::C_CLK_PREP && r.ccnt + 8'h01 <= cdhls_pkg::C_CLK_PREP_MAX))
		else $error("clock prepare out of range");
	chk_clk_zero_len: assert property ((r.cst == cdhls_pkg::CK_ZERO && n.cst == cdhls_pkg::CK_RUN)
		|-> (r.ccnt + 8'h01 + cdhls_pkg::C_CLK_PREP >= cdhls_pkg::C_CLK_PZ))
		else $error("clock prepare plus zero too short");
	chk_hs_prep_max: assert property ((r.dst == cdhls_pkg::D_PREP && n.dst == cdhls_pkg::D_ZERO)
		|-> (r.dcnt + 8'h01 <= cdhls_pkg::C_HS_PREP_MAX))
		else $error("data prepare too long");
	chk_hs_zero_len: assert property ((r.dst == cdhls_pkg::D_ZERO && n.dst == cdhls_pkg::D_SYNC)
		|-> (r.dcnt + 8'h01 + cdhls_pkg::C_HS_PREP >= cdhls_pkg::C_HS_PZ))
		else $error("data prepare plus zero too short");
	chk_trail_min: assert property ((r.dst == cdhls_pkg::D_TRAIL && n.dst == cdhls_pkg::D_STOP)
		|-> (r.dcnt + 8'h01 >= cdhls_pkg::C_TRAIL))
		else $error("trail too short");
	// Trail drives the inverse of each data lane's final bit
	for (genvar t = 0; t < cdhls_pkg::LANES; t++) begin : g_chk_trail
		chk_trail_level: assert property ((r.trail && !cfg_lane_is_clk[t])
			|-> ((wire_p[t] ^ cfg_inv_p[t]) == ~r.lastb[t]))
			else $error("trail level not inverted last bit");
	end
	chk_eot_max: assert property ((r.dst == cdhls_pkg::D_TRAIL && n.dst == cdhls_pkg::D_STOP)
		|-> (r.dcnt + 8'h01 <= cdhls_pkg::C_EOT_MAX))
		else $error("end of transmission too long");
	chk_exit_min: assert property ((r.dst == cdhls_pkg::D_STOP && n.dst == cdhls_pkg::D_REQ) |-> (r.dcnt >= cdhls_pkg::C_EXIT))
		else $error("stop state too short");
	chk_lpx_req: assert property ((r.dst == cdhls_pkg::D_REQ && n.dst == cdhls_pkg::D_PREP)
		|-> (r.dcnt + 8'h01 >= cdhls_pkg::C_LPX))
		else $error("request state too short");
	chk_burst_order: assert property ((r.dst != n.dst) |-> (n.dst == d_succ(r.dst)))
		else $error("burst state out of order");
	// A burst only runs while the clock lane toggles
	chk_burst_clk_on: assert property ((r.dst != cdhls_pkg::D_STOP)
		|-> (r.cst == cdhls_pkg::CK_RUN && r.pre_ok))
		else $error("burst without running clock");
	// Running clock lane is always in high speed
	chk_clk_run_hs: assert property ((r.cst == cdhls_pkg::CK_RUN)
		|-> (r.ck_o == cdhls_pkg::LP_HS))
		else $error("running clock lane not in high speed");
	// One word per handshake round trip
	chk_ready_single: assert property (pay_ready
		|=> !pay_ready)
		else $error("ready held for two cycles");
	// Words only taken in the payload phase
	chk_ready_in_pay: assert property (pay_ready
		|-> (r.dst == cdhls_pkg::D_PAY && pay.valid && !busy))
		else $error("word taken outside payload phase");
	// Stop state shows LP-11 on a data lane
	chk_stop_level: assert property ((r.dst == cdhls_pkg::D_STOP && !cfg_lane_is_clk[1])
		|-> ((wire_p[1] ^ cfg_inv_p[1]) && (wire_n[1] ^ cfg_inv_n[1]) && !lane_hs[1]))
		else $error("stop state not LP-11");
	// Prepare shows LP-00 on a data lane
	chk_prep_level: assert property ((r.dst == cdhls_pkg::D_PREP && !cfg_lane_is_clk[1])
		|-> (!(wire_p[1] ^ cfg_inv_p[1]) && !(wire_n[1] ^ cfg_inv_n[1]) && !lane_hs[1]))
		else $error("prepare state not LP-00");
	// Clock lane off means low power
	chk_clk_off_lp: assert property ((r.cst == cdhls_pkg::CK_OFF && cfg_lane_is_clk[0])
		|-> !lane_hs[0])
		else $error("idle clock lane in high speed");

	cov_clk_run: cover property (r.cst == cdhls_pkg::CK_ZERO ##1 r.cst == cdhls_pkg::CK_RUN);
	cov_burst_done: cover property (r.dst == cdhls_pkg::D_TRAIL ##1 r.dst == cdhls_pkg::D_STOP);
	cov_pay_stall: cover property (r.dst == cdhls_pkg::D_PAY && pay.valid && busy);
	cov_disable: cover property (r.cst == cdhls_pkg::CK_RUN ##1 r.cst == cdhls_pkg::CK_OFF);
	cov_word_chain: cover property (pay_ready && !pay.last);
endmodule : cdhls_lane_seq

// file: verif/cdhls_rx_model.sv
/*
 * Receiver model for one lane: measures line-state run lengths in clk cycles.
 * Assumes lane wires only change at system clock edges or slower.
 */
module cdhls_rx_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Lane wires and polarity
	input wire logic wp,
	input wire logic wn,
	input wire logic hs,
	input wire logic inv_p,
	input wire logic inv_n,
	// Measured run lengths and short-state violation flag
	output logic [15:0] l_req,
	output logic [15:0] l_prep,
	output logic [15:0] l_hs_first,
	output logic [15:0] l_hs_last,
	output logic [15:0] l_stop,
	output logic viol
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] code;
	logic [2:0] prev;
	logic [15:0] cnt;
	logic first;
	// Line state with board polarity undone
	assign code = {hs, wp ^ inv_p, wn ^ inv_n};
	// Run length capture on every change of line state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev <= 3'h3;
			cnt <= 16'h0000;
			first <= 1'b0;
			viol <= 1'b0;
			l_req <= 16'h0000;
			l_prep <= 16'h0000;
			l_hs_first <= 16'h0000;
			l_hs_last <= 16'h0000;
			l_stop <= 16'h0000;
		end else if (code == prev) begin
			cnt <= cnt + 16'h0001;
		end else begin
			cnt <= 16'h0001;
			prev <= code;
			first <= (prev == 3'h0) && code[2];
			// Short low-power state, prepare has its own bounds
			if (!prev[2] && prev != 3'h0 && cnt < 16'h0005) begin
				viol <= 1'b1;
			end
			case (prev)
				3'h1: l_req <= cnt;
				3'h0: l_prep <= cnt;
				3'h3: l_stop <= cnt;
				default: ;
			endcase
			if (prev[2] && first) begin
				l_hs_first <= cnt;
			end
			if (prev[2] && !code[2]) begin
				l_hs_last <= cnt;
			end
		end
	end
endmodule : cdhls_rx_model

// file: verif/tb.sv
/*
 * Self-checking bench for the lane sequencer: bring-up, bursts, deferred disable.
 * Assumes lane 0 is the clock lane and lanes 1 to 3 carry data.
 */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic last; logic [31:0] data; logic [2:0] exp_p;} cdhls_row_t;
	localparam logic [3:0] INV_P = 4'b1000;
	localparam logic [3:0] INV_N = 4'b0010;
	// Words and expected trail level on wire_p of lanes 3..1
	localparam cdhls_row_t ROWS [4] = '{
		'{1'b1, 32'h8000_0000, 3'b111},
		'{1'b0, 32'h1234_5678, 3'b000},
		'{1'b1, 32'h7f00_7f00, 3'b011},
		'{1'b1, 32'hff80_0011, 3'b101}};
	logic clk;
	logic rst_n;
	logic link_clk;
	logic cfg_enable;
	cdhls_pkg::cdhls_pay_t pay;
	logic pay_ready;
	logic [3:0] wire_p;
	logic [3:0] wire_n;
	logic [3:0] lane_hs;
	logic clk_running;
	logic [3:0] trail_p;
	logic [15:0] lr [2];
	logic [15:0] lp [2];
	logic [15:0] lf [2];
	logic [15:0] ll [2];
	logic [15:0] ls [2];
	logic vio [2];
	int err_total;
	int cmp_count;
	cdhls_lane_seq u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .link_clk(link_clk), .cfg_enable(cfg_enable),
		.cfg_lane_is_clk(4'h1), .cfg_inv_p(INV_P), .cfg_inv_n(INV_N), .pay(pay), .pay_ready(pay_ready),
		.wire_p(wire_p), .wire_n(wire_n), .lane_hs(lane_hs), .clk_running(clk_running));
	// Receiver models on the clock lane and one data lane
	for (genvar g = 0; g < 2; g++) begin : g_rx
		cdhls_rx_model u_rx (.clk(clk), .rst_n(rst_n), .wp(wire_p[g]), .wn(wire_n[g]), .hs(lane_hs[g]),
			.inv_p(INV_P[g]), .inv_n(INV_N[g]), .l_req(lr[g]), .l_prep(lp[g]), .l_hs_first(lf[g]),
			.l_hs_last(ll[g]), .l_stop(ls[g]), .viol(vio[g]));
	end
	// System clock, and link clock offset in phase
	always #5 clk = ~clk;
	initial begin
		link_clk = 1'b0;
		#7;
		forever #24 link_clk = ~link_clk;
	end
	// Last wire_p seen while lane 1 is in high speed
	always @(posedge clk) begin
		if (lane_hs[1]) begin
			trail_p <= wire_p;
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop
	// Offer one word and hold it until the handshake edge
	task automatic send_word(input logic last, input logic [31:0] data);
		int k;
		@(posedge clk);
		pay <= '{valid: 1'b1, last: last, data: data};
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pay_ready !== 1'b1 && k < 3000);
		pay <= '0;
		check(k < 3000, 1);
	endtask : send_word
	// Wait, sampling at the falling edge, until a lane leaves high speed
	task automatic wait_fall(input int lane);
		int k;
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (lane_hs[lane] !== 1'b0 && k < 3000);
		check(k < 3000, 1);
	endtask : wait_fall
	// Watchdog
	initial begin
		#200000;
		err_total++;
		report_and_stop();
	end
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		cfg_enable = 1'b0;
		pay = '0;
		err_total = 0;
		cmp_count = 0;
		repeat (4) @(posedge clk);
		// Reset state: every lane in stop state after polarity
		check(wire_p, 4'(~INV_P));
		check(wire_n, 4'(~INV_N));
		check({lane_hs, clk_running}, 5'h00);
		rst_n <= 1'b1;
		@(posedge clk);
		cfg_enable <= 1'b1;
		$display("test reset done");
		// Clock lane bring-up
		do @(negedge clk); while (clk_running !== 1'b1 && cmp_count < 100 && $time < 20000);
		check(clk_running, 1'b1);
		check(lr[0] >= 5, 1);
		check(lp[0] >= 4 && lp[0] <= 9, 1);
		check(lp[0] + lf[0] >= 30, 1);
		check(lane_hs, 4'h1);
		check(wire_p[3:1], 3'b011);
		$display("test bring-up done");
		// Ordinary bursts, rows 1 and 2 back to back
		foreach (ROWS[r]) begin
			send_word(ROWS[r].last, ROWS[r].data);
			if (ROWS[r].last) begin
				wait_fall(1);
				@(negedge clk);
				check(trail_p[3:1], ROWS[r].exp_p);
				check(ll[1], 16'h000c);
				check(lane_hs[0], 1'b1);
			end
			$display("test row %0d done", r);
		end
		check(lr[1] >= 5, 1);
		check(lp[1] >= 5 && lp[1] <= 9, 1);
		check(lp[1] + lf[1] >= 28, 1);
		check(ls[1] >= 10, 1);
		check({vio[0], vio[1]}, 2'h0);
		// Disable in mid-burst is deferred to the burst end
		send_word(1'b1, 32'h0101_0101);
		cfg_enable <= 1'b0;
		@(negedge clk);
		check(lane_hs[0], 1'b1);
		wait_fall(1);
		wait_fall(0);
		check({wire_p[0], wire_n[0]}, 2'h3);
		$display("test disable done");
		report_and_stop();
	end
endmodule : tb
